// *** src/posture_detect.sv ***
// Posture detection with APB register access and two interrupt pins
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module posture_detect (
  input  wire logic                      clk_sys,      // 20 MHz system clock
  input  wire logic                      rst,          // Async reset, active high
  input  wire logic                      psel,         // APB select
  input  wire logic                      penable,      // APB access phase
  input  wire logic                      pwrite,       // APB direction
  input  wire logic [7:0]                paddr,        // APB byte address
  input  wire logic [31:0]               pwdata,       // APB write data
  output logic                           pready,       // APB ready
  output logic [31:0]                    prdata,       // APB read data
  output logic                           pslverr,      // APB error, unmapped
  input  wire logic                      sample_valid, // New output sample strobe
  input  wire posture_pkg::accel_sample_t sample,      // Acceleration sample
  input  wire logic                      overrun_evt,  // Overrun event pulse
  output logic                           irq_pin_a,    // Interrupt pin A
  output logic                           irq_pin_b     // Interrupt pin B
);
  import posture_pkg::*;

  logic [7:0]            sample_rate_ctl_r;
  logic [7:0]            power_ctl_r;
  logic [7:0]            int_enable_r;
  logic [7:0]            int_map_r;
  logic [7:0]            posture_config_r;
  posture_status_t       status_r;
  posture_status_t       status_nxt;
  accel_sample_t         filt_r;
  accel_sample_t         filt_nxt;
  logic                  filt_empty_r;
  logic                  posture_pend_r;
  logic                  posture_pend_nxt;
  logic                  overrun_pend_r;
  logic                  overrun_pend_nxt;

  function automatic logic [16:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
  endfunction : mag

  // First-order IIR; shift approximates the divisor
  function automatic logic signed [15:0] lowpass(input logic signed [15:0] f,
                                                 input logic signed [15:0] x,
                                                 input logic [3:0]         sh);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    diff    = 17'($signed(x) - $signed(f));
    step    = diff >>> sh;
    lowpass = 16'($signed(f) + step);
  endfunction : lowpass

  // Minor axis must stay inside the cone of the major axis
  function automatic logic outside_dz(input logic [16:0] major,
                                      input logic [16:0] minor,
                                      input logic [7:0]  ratio);
    logic [24:0] lhs;
    logic [24:0] rhs;
    lhs        = {minor, 8'h00};
    rhs        = 25'(major * ratio);
    outside_dz = lhs < rhs;
  endfunction : outside_dz

  // APB decode
  wire        apb_setup   = psel & ~penable;
  wire        apb_done    = psel & penable & pready;
  wire [5:0]  reg_idx     = paddr[7:2];
  wire        wr_done     = apb_done & pwrite;
  wire        rd_done     = apb_done & ~pwrite;
  wire        hit_rate    = reg_idx == IDX_SAMPLE_RATE_CTL;
  wire        hit_power   = reg_idx == IDX_POWER_CTL;
  wire        hit_enable  = reg_idx == IDX_INT_ENABLE;
  wire        hit_map     = reg_idx == IDX_INT_MAP;
  wire        hit_source  = reg_idx == IDX_INT_SOURCE;
  wire        hit_config  = reg_idx == IDX_POSTURE_CONFIG;
  wire        hit_status  = reg_idx == IDX_POSTURE_STATUS;
  wire        mapped      = hit_rate | hit_power | hit_enable | hit_map | hit_source | hit_config | hit_status;

  // Configuration fields
  wire        posture_int_en     = posture_config_r[POS_CFG_INT_EN];
  wire [2:0]  dz_code            = posture_config_r[POS_CFG_DZ_LO +: 3];
  wire        posture_dim_select = posture_config_r[POS_CFG_DIM_SEL];
  wire [2:0]  div_code           = posture_config_r[POS_CFG_DIV_LO +: 3];
  wire        slot_enable        = int_enable_r[POS_SLOT0];
  wire        slot_to_b          = int_map_r[POS_SLOT0];
  wire        standby            = ~power_ctl_r[POS_MEASURE];

  // Feature reset: rate write or standby
  wire        feature_reset = (wr_done & hit_rate) | standby;
  wire        take_sample   = sample_valid & ~feature_reset;
  wire        source_read   = rd_done & hit_source;

  // Filter; an empty filter loads the sample directly
  wire [3:0]  shift = DIV_SHIFT[div_code];
  assign filt_nxt.x = filt_empty_r ? sample.x : lowpass(filt_r.x, sample.x, shift);
  assign filt_nxt.y = filt_empty_r ? sample.y : lowpass(filt_r.y, sample.y, shift);
  assign filt_nxt.z = filt_empty_r ? sample.z : lowpass(filt_r.z, sample.z, shift);

  wire [16:0] ax = mag(filt_nxt.x);
  wire [16:0] ay = mag(filt_nxt.y);
  wire [16:0] az = mag(filt_nxt.z);
  wire [7:0]  ratio = DZ_RATIO[dz_code];

  // Planar classification from X and Y
  wire        p_x_dom   = ax >= ay;
  wire [1:0]  p_code    = p_x_dom ? (filt_nxt.x[15] ? P2_NEG_X : P2_POS_X)
                                  : (filt_nxt.y[15] ? P2_NEG_Y : P2_POS_Y);
  wire        p_valid   = p_x_dom ? outside_dz(ax, ay, ratio) : outside_dz(ay, ax, ratio);

  // Spatial classification from all three axes
  wire        s_x_dom   = (ax >= ay) & (ax >= az);
  wire        s_y_dom   = ~s_x_dom & (ay >= az);
  wire [16:0] s_major   = s_x_dom ? ax : (s_y_dom ? ay : az);
  wire [16:0] s_minor   = s_x_dom ? ((ay >= az) ? ay : az)
                                  : (s_y_dom ? ((ax >= az) ? ax : az) : ((ax >= ay) ? ax : ay));
  wire [2:0]  s_code    = s_x_dom ? (filt_nxt.x[15] ? P3_NEG_X : P3_POS_X)
                        : s_y_dom ? (filt_nxt.y[15] ? P3_NEG_Y : P3_POS_Y)
                                  : (filt_nxt.z[15] ? P3_NEG_Z : P3_POS_Z);
  wire        s_valid   = outside_dz(s_major, s_minor, ratio);

  // Status refresh; an invalid result holds the previous code
  assign status_nxt.zero7         = 1'b0;
  assign status_nxt.planar_valid  = p_valid;
  assign status_nxt.planar_code   = p_valid ? p_code : status_r.planar_code;
  assign status_nxt.spatial_valid = s_valid;
  assign status_nxt.spatial_code  = s_valid ? s_code : status_r.spatial_code;

  // Held code is the last valid one, so a differing valid code is a valid-to-valid move.
  // After feature reset the held code is the default, which makes the next differing sample fire.
  wire        change_2d = p_valid & (p_code != status_r.planar_code);
  wire        change_3d = s_valid & (s_code != status_r.spatial_code);
  wire        change    = posture_dim_select ? change_3d : change_2d;
  wire        posture_armed = posture_int_en & slot_enable;
  wire        posture_set   = take_sample & change & posture_armed;

  // Set beats a source read in the same cycle; disable and feature reset win over both
  always_comb
  begin
    posture_pend_nxt = posture_pend_r;
    if (source_read)
      posture_pend_nxt = 1'b0;
    if (posture_set)
      posture_pend_nxt = 1'b1;
    if (~posture_armed | feature_reset)
      posture_pend_nxt = 1'b0;
  end

  // Overrun keeps the slot only while posture is off
  always_comb
  begin
    overrun_pend_nxt = overrun_pend_r;
    if (source_read)
      overrun_pend_nxt = 1'b0;
    if (overrun_evt & ~posture_int_en)
      overrun_pend_nxt = 1'b1;
    if (posture_int_en)
      overrun_pend_nxt = 1'b0;
  end

  wire        slot_flag   = posture_int_en ? posture_pend_r : overrun_pend_r;
  wire        slot_irq    = slot_flag & slot_enable;
  wire [7:0]  source_val  = {7'h00, slot_flag};

  // Read mux
  wire [7:0]  rd_byte = hit_rate   ? sample_rate_ctl_r :
                        hit_power  ? power_ctl_r       :
                        hit_enable ? int_enable_r      :
                        hit_map    ? int_map_r         :
                        hit_source ? source_val        :
                        hit_config ? posture_config_r  :
                        hit_status ? 8'(status_r)      : 8'h00;

  // APB slave: answer registered in the setup cycle, ready in the access cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_setup;
      prdata  <= (apb_setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= apb_setup & ~mapped;
    end
  end

  // Software registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sample_rate_ctl_r <= RST_SAMPLE_RATE;
      power_ctl_r       <= RST_ZERO;
      int_enable_r      <= RST_ZERO;
      int_map_r         <= RST_ZERO;
      posture_config_r  <= RST_CONFIG;
    end
    else if (wr_done)
    begin
      if (hit_rate)
        sample_rate_ctl_r <= pwdata[7:0];
      if (hit_power)
        power_ctl_r <= pwdata[7:0];
      if (hit_enable)
        int_enable_r <= pwdata[7:0];
      if (hit_map)
        int_map_r <= pwdata[7:0];
      if (hit_config)
        posture_config_r <= pwdata[7:0];
    end
  end

  // Filter and status
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      filt_r       <= '0;
      filt_empty_r <= 1'b1;
      status_r     <= STATUS_DEFAULT;
    end
    else if (feature_reset)
    begin
      filt_r       <= '0;
      filt_empty_r <= 1'b1;
      status_r     <= STATUS_DEFAULT;
    end
    else if (take_sample)
    begin
      filt_r       <= filt_nxt;
      filt_empty_r <= 1'b0;
      status_r     <= status_nxt;
    end
  end

  // Pending flags and pins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      posture_pend_r <= 1'b0;
      overrun_pend_r <= 1'b0;
      irq_pin_a      <= 1'b0;
      irq_pin_b      <= 1'b0;
    end
    else
    begin
      posture_pend_r <= posture_pend_nxt;
      overrun_pend_r <= overrun_pend_nxt;
      irq_pin_a      <= slot_irq & ~slot_to_b;
      irq_pin_b      <= slot_irq & slot_to_b;
    end
  end

endmodule : posture_detect
`default_nettype wire

// *** src/posture_pkg.sv ***
// Constants, register map and carrier types of the posture detection block
// Overview of operation
// - Posture enable bit swaps posture into the overrun slot of map, enable, source.
// - Interrupt raised whenever the selected dimension's orientation changes to a different valid code.
// - Reading the interrupt source register clears a pending posture interrupt.
// - Clearing either posture enable bit disables and clears the posture interrupt.
// - Rate register write or standby empties filter, clears posture interrupt (not overrun), defaults status.
// - After posture reset, first differing sample interrupts; 2D default +X.
// - Posture enable at 0 gives no posture interrupt; overrun keeps its slot.
// - Inside the dead zone orientation is invalid and its code is held.
// - Three-bit dead-zone code maps to angles 5.1 to 41.4 degrees.
// - Filter bandwidth is the sample rate divided by 9 up to 1600.
// - Select bit 0: interrupt only on valid-to-different-valid 2D change.
// - Select bit 1: interrupt only on valid-to-different-valid 3D change.
// - Status bit 6 flags valid 2D, bit 3 flags valid 3D.
// - Posture status refreshes with every new acceleration sample.
// - 2D code: 00 +X, 01 -X, 10 +Y, 11 -Y.
// - 3D code: 011 +X, 100 -X, 010 +Y, 101 -Y, 001 +Z, 110 -Z.
package posture_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SAMPLE_RATE_CTL = 6'h2c;
  localparam logic [5:0] IDX_POWER_CTL       = 6'h2d;
  localparam logic [5:0] IDX_INT_ENABLE      = 6'h2e;
  localparam logic [5:0] IDX_INT_MAP         = 6'h2f;
  localparam logic [5:0] IDX_INT_SOURCE      = 6'h30;
  localparam logic [5:0] IDX_POSTURE_CONFIG  = 6'h3b;
  localparam logic [5:0] IDX_POSTURE_STATUS  = 6'h3c;

  // Field positions
  localparam int POS_SLOT0        = 0; // Overrun / posture slot in map, enable, source
  localparam int POS_MEASURE      = 3; // Power control: 1 measure, 0 standby
  localparam int POS_CFG_INT_EN   = 7;
  localparam int POS_CFG_DZ_LO    = 4;
  localparam int POS_CFG_DIM_SEL  = 3;
  localparam int POS_CFG_DIV_LO   = 0;

  // Reset values
  localparam logic [7:0] RST_SAMPLE_RATE = 8'h0a;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_CONFIG      = 8'h25;

  // 2D and 3D orientation codes
  localparam logic [1:0] P2_POS_X = 2'h0;
  localparam logic [1:0] P2_NEG_X = 2'h1;
  localparam logic [1:0] P2_POS_Y = 2'h2;
  localparam logic [1:0] P2_NEG_Y = 2'h3;
  localparam logic [2:0] P3_NONE  = 3'h0;
  localparam logic [2:0] P3_POS_Z = 3'h1;
  localparam logic [2:0] P3_POS_Y = 3'h2;
  localparam logic [2:0] P3_POS_X = 3'h3;
  localparam logic [2:0] P3_NEG_X = 3'h4;
  localparam logic [2:0] P3_NEG_Y = 3'h5;
  localparam logic [2:0] P3_NEG_Z = 3'h6;

  // Dead-zone angles in tenths of a degree, code 0..7
  localparam int DZ_ANGLE_TENTHS [8] = '{51, 102, 152, 204, 255, 308, 361, 414};
  // tan(45 deg - angle/2) in 1/256 units: minor/major must stay below this
  localparam logic [7:0] DZ_RATIO [8] = '{8'hea, 8'hd6, 8'hc4, 8'hb2, 8'ha2, 8'h91, 8'h82, 8'h74};
  // Filter divisors; shift is the nearest power of two
  localparam int         DIVISOR    [8] = '{9, 22, 50, 100, 200, 400, 800, 1600};
  localparam logic [3:0] DIV_SHIFT  [8] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } accel_sample_t;

  typedef struct packed {
    logic       zero7;
    logic       planar_valid;
    logic [1:0] planar_code;
    logic       spatial_valid;
    logic [2:0] spatial_code;
  } posture_status_t;

  localparam posture_status_t STATUS_DEFAULT = '{1'b0, 1'b0, P2_POS_X, 1'b0, P3_NONE};

endpackage : posture_pkg

// *** test/posture_detect_monitor.sv ***
// Port-level checker for the posture block
`timescale 1ns/1ns
`default_nettype none
module posture_detect_monitor (
  input wire logic        clk_sys,      // System clock
  input wire logic        rst,          // Async reset
  input wire logic        psel,         // APB select
  input wire logic        penable,      // APB access
  input wire logic        pwrite,       // APB direction
  input wire logic [7:0]  paddr,        // APB address
  input wire logic        pready,       // APB ready
  input wire logic [31:0] prdata,       // APB read data
  input wire logic        pslverr,      // APB error
  input wire logic        sample_valid, // Sample strobe
  input wire logic        overrun_evt,  // Overrun pulse
  input wire logic        irq_pin_a,    // Pin A
  input wire logic        irq_pin_b     // Pin B
);
  import posture_pkg::*;
  logic setup;
  logic rd_src;
  logic wr_done;
  logic mapped;
  assign setup   = psel && !penable;
  assign rd_src  = psel && penable && pready && !pwrite && paddr[7:2] == IDX_INT_SOURCE;
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped  = (paddr[7:2] >= IDX_SAMPLE_RATE_CTL && paddr[7:2] <= IDX_INT_SOURCE)
                   || paddr[7:2] == IDX_POSTURE_CONFIG || paddr[7:2] == IDX_POSTURE_STATUS;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ready_after_setup; setup |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  property p_ready_cause; pready |-> $past(setup); endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("pready held too long");
  property p_err; setup |=> pslverr == !$past(mapped); endproperty
  a_err: assert property (p_err)
    else $error("pslverr does not match decode");
  property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits set");
  property p_status_bit7; setup && !pwrite && paddr[7:2] == IDX_POSTURE_STATUS |=> pready && !prdata[7]; endproperty
  a_status_bit7: assert property (p_status_bit7)
    else $error("status bit 7 set");
  property p_src_clear; rd_src && !sample_valid && !overrun_evt ##1 !sample_valid && !overrun_evt
    |=> !irq_pin_a && !irq_pin_b; endproperty
  a_src_clear: assert property (p_src_clear)
    else $error("interrupt not cleared by source read");
  property p_irq_cause; $rose(irq_pin_a) || $rose(irq_pin_b)
    |-> $past(sample_valid, 2) || $past(overrun_evt, 2) || $past(wr_done, 2); endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without cause");
endmodule : posture_detect_monitor
bind posture_detect posture_detect_monitor mon (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sample_valid(sample_valid), .overrun_evt(overrun_evt), .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
`default_nettype wire

// *** test/posture_host.sv ***
// Host model: APB master that sets up and polls the posture block
`timescale 1ns/1ns
`default_nettype none
module posture_host (
  input  wire logic        clk_sys, // System clock
  input  wire logic        pready,  // APB ready
  input  wire logic [31:0] prdata,  // APB read data
  input  wire logic        pslverr, // APB error
  output logic             psel,    // APB select
  output logic             penable, // APB access
  output logic             pwrite,  // APB direction
  output logic [7:0]       paddr,   // APB address
  output logic [31:0]      pwdata   // APB write data
);
  import posture_pkg::*;
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // Released address and data lines show the inverse so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~{24'h0, d};
  endtask : xfer
  task automatic posture_on(input logic [7:0] cfg, input logic pin_b);
    logic [7:0] q;
    logic       e;
    xfer(1'b1, {IDX_POSTURE_CONFIG, 2'b00}, cfg[6:4] == 3'h0 ? cfg | 8'h10 : cfg, q, e);
    xfer(1'b1, {IDX_INT_MAP, 2'b00}, {7'h0, pin_b}, q, e);
    xfer(1'b1, {IDX_INT_ENABLE, 2'b00}, 8'h01, q, e);
  endtask : posture_on
endmodule : posture_host
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for posture detection
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import posture_pkg::*;
  logic          clk_sys, rst, sample_valid, overrun_evt, irq_pin_a, irq_pin_b;
  logic          psel, penable, pwrite, pready, pslverr, e, neg, pb, irq;
  logic [7:0]    paddr, q, ex;
  logic [31:0]   pwdata, prdata;
  logic [1:0]    ax;
  accel_sample_t sample;
  int            fails, cmp_count, cyc, m, c, f, n;
  posture_detect dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample(sample), .overrun_evt(overrun_evt),
    .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
  posture_host host (.clk_sys(clk_sys), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    cmp_count++;
    if (got !== want)
    begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    host.xfer(1'b1, {i, 2'b00}, d, q, e);
  endtask : wr
  task automatic rd(input logic [5:0] i);
    host.xfer(1'b0, {i, 2'b00}, 8'h00, q, e);
  endtask : rd
  task automatic pins(input logic a, input logic b);
    chk({6'h0, irq_pin_b, irq_pin_a}, {6'h0, b, a}, "pins");
  endtask : pins
  // Waits out the one-cycle pin lag so pins are settled on return
  task automatic shot(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z, input logic ov);
    @(posedge clk_sys);
    sample       <= '{x, y, z};
    sample_valid <= !ov;
    overrun_evt  <= ov;
    @(posedge clk_sys);
    sample       <= ~{x, y, z};
    sample_valid <= 1'b0;
    overrun_evt  <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : shot
  task automatic orient(input logic [1:0] a, input logic n);
    logic [15:0] v;
    v = n ? -m[15:0] : m[15:0];
    shot(a == 2'd0 ? v : (a == 2'd2 ? m[15:0] >> 2 : 16'h0), a == 2'd1 ? v : 16'h0, a == 2'd2 ? v : 16'h0, 1'b0);
  endtask : orient
  function automatic logic [7:0] want_st(input logic [1:0] a, input logic n);
    logic [2:0] s;
    s = a == 2'd0 ? (n ? 3'h4 : 3'h3) : a == 2'd1 ? (n ? 3'h5 : 3'h2) : (n ? 3'h6 : 3'h1);
    return {2'b01, a == 2'd2 ? 2'b00 : {a[0], n}, 1'b1, s};
  endfunction : want_st
  // Minor axis one degree inside (s 0) or outside (s 1) the valid cone of a 4000 major axis
  function automatic logic [15:0] dz_minor(input int d, input int s);
    real b;
    b = (45.0 - DZ_ANGLE_TENTHS[d] / 20.0 + (s == 0 ? -1.0 : 1.0)) * 3.14159265 / 180.0;
    return 16'($rtoi(4000.0 * $tan(b)));
  endfunction : dz_minor
  // Reference low-pass step
  function automatic int iir(input int fo, input int x, input int k);
    return fo + ((x - fo) >>> k);
  endfunction : iir
  // Back-to-back samples on X only, one per cycle
  task automatic feed(input logic [15:0] x, input int cnt);
    repeat (cnt)
    begin
      @(posedge clk_sys);
      sample       <= '{x, 16'h0, 16'h0};
      sample_valid <= 1'b1;
    end
    @(posedge clk_sys);
    sample_valid <= 1'b0;
  endtask : feed
  initial
  begin
    {rst, sample_valid, overrun_evt, sample} = {1'b1, 50'h0};
    void'($urandom(26673));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(IDX_SAMPLE_RATE_CTL);
    chk(q, RST_SAMPLE_RATE, "rate reset");
    rd(IDX_POSTURE_CONFIG);
    chk(q, RST_CONFIG, "config reset");
    wr(IDX_POSTURE_STATUS, 8'hff);
    rd(IDX_POSTURE_STATUS);
    chk(q, 8'h00, "status read only");
    rd(6'h3f);
    chk({q[7:1], e}, 8'h01, "unmapped");
    wr(IDX_POWER_CTL, 8'h08);
    for (int k = 0; k < 16; k++)
    begin
      ax = 2'($urandom % 3);
      neg = 1'($urandom);
      pb = 1'($urandom);
      m = 200 + $urandom % 16000;
      ex = want_st(ax, neg);
      irq = k[0] || ex[5:4] != 2'b00;
      host.posture_on({1'b1, 3'($urandom % 7 + 1), k[0], 3'h0}, pb);
      wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
      orient(ax, neg);
      rd(IDX_POSTURE_STATUS);
      chk(q, ex, "status");
      pins(irq && !pb, irq && pb);
      rd(IDX_INT_SOURCE);
      chk({7'h0, q[0]}, {7'h0, irq}, "source");
      repeat (2) @(posedge clk_sys);
      pins(1'b0, 1'b0);
    end
    m = 4000;
    for (int j = 0; j < 2; j++)
    begin
      host.posture_on(8'h98, 1'b0);
      wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
      orient(2'd2, 1'b0);
      pins(1'b1, 1'b0);
      wr(j == 0 ? IDX_POSTURE_CONFIG : IDX_INT_ENABLE, j == 0 ? 8'h18 : 8'h00);
      repeat (2) @(posedge clk_sys);
      pins(1'b0, 1'b0);
      // Re-enable: a pending flag that survived the disable would show here
      wr(j == 0 ? IDX_POSTURE_CONFIG : IDX_INT_ENABLE, j == 0 ? 8'h98 : 8'h01);
      rd(IDX_INT_SOURCE);
      chk({7'h0, q[0]}, 8'h00, "disable clears pending");
    end
    host.posture_on(8'h98, 1'b1);
    wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
    orient(2'd0, 1'b1);
    pins(1'b0, 1'b1);
    wr(IDX_POWER_CTL, 8'h00);
    // Standby is registered, then clears pending, then the pin follows
    repeat (3) @(posedge clk_sys);
    pins(1'b0, 1'b0);
    rd(IDX_POSTURE_STATUS);
    chk(q, 8'h00, "standby status");
    wr(IDX_POWER_CTL, 8'h08);
    wr(IDX_POSTURE_CONFIG, 8'h18);
    wr(IDX_INT_MAP, 8'h00);
    shot(16'h0, 16'h0, 16'h0, 1'b1);
    pins(1'b1, 1'b0);
    rd(IDX_INT_SOURCE);
    chk({7'h0, q[0]}, 8'h01, "overrun source");
    wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
    orient(2'd1, 1'b1);
    pins(1'b0, 1'b0);
    host.posture_on(8'h90, 1'b0);
    shot(16'h0, 16'h0, 16'h0, 1'b1);
    pins(1'b0, 1'b0);
    for (int d = 0; d < 8; d++)
    begin
      wr(IDX_POSTURE_CONFIG, {1'b1, 3'(d), 4'h0});
      wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
      shot(16'h0800, 16'h0800, 16'h0, 1'b0);
      pins(1'b0, 1'b0);
      rd(IDX_POSTURE_STATUS);
      chk(q, 8'h00, "dead zone");
      // Just inside and just outside the cone edge for this code
      for (int s = 0; s < 2; s++)
      begin
        wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
        shot(16'h0fa0, dz_minor(d, s), 16'h0, 1'b0);
        rd(IDX_POSTURE_STATUS);
        chk(q, s == 0 ? 8'h4b : 8'h00, "dead zone edge");
      end
    end
    // Step from +X to -X: the flip must land on the sample the reference filter predicts
    c = $urandom % 8;
    wr(IDX_POSTURE_CONFIG, {5'h02, 3'(c)});
    wr(IDX_SAMPLE_RATE_CTL, 8'h0a);
    feed(16'h0fa0, 1);
    f = 4000;
    n = 0;
    while (f > 0)
    begin
      f = iir(f, -4000, DIV_SHIFT[c]);
      n++;
    end
    feed(16'hf060, n - 1);
    rd(IDX_POSTURE_STATUS);
    chk(q, 8'h4b, "filter before flip");
    feed(16'hf060, 1);
    rd(IDX_POSTURE_STATUS);
    chk(q, f < 0 ? 8'h5c : 8'h03, "filter flip");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
